// *** hw/msxe_pkg.sv ***
// shared constants and types for the swap/skip/table/xor execution block
package msxe_pkg;
  localparam int DATA_W  = 8;
  localparam int ROM_W   = 15;
  localparam int ROM_AW  = 12;
  localparam int PAGE_W  = ROM_AW - DATA_W;
  localparam int HIGH_W  = ROM_W - DATA_W;
  localparam int FLAG_W  = 8;
  localparam int ZERO_BIT = 2;
  localparam logic [DATA_W-1:0] WREG_RST  = 8'h00;
  localparam logic [HIGH_W-1:0] TABLE_HIGH_RST = 7'h00;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 8'h00;
  localparam logic [PAGE_W-1:0] LAST_PAGE = 4'hf;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_NIBBLE_EXCHANGE_TO_WREG,
    OP_SKIP_IF_NULL_BYTE,
    OP_COPY_THEN_SKIP_IF_NULL,
    OP_SKIP_IF_BIT_CLEAR,
    OP_TABLE_READ_CURRENT_PAGE,
    OP_TABLE_READ_LAST_PAGE,
    OP_XOR_WREG_MEM,
    OP_EXCLUSIVE_OR_INTO_MEMORY,
    OP_XOR_WREG_IMM
  } msxe_op_t;
endpackage

// *** hw/msxe_alu.sv ***
// combinational result unit: swap, xor, zero detect
`timescale 1ns/1ps
module msxe_alu
  import msxe_pkg::*;
(
  // operands
  input  wire logic [DATA_W-1:0] opA,
  input  wire logic [DATA_W-1:0] opB,
  // results
  output logic      [DATA_W-1:0] swapOut,
  output logic      [DATA_W-1:0] xorOut,
  output logic                   xorZero,
  output logic                   opBZero
);
  always_comb begin
    swapOut = {opB[3:0], opB[7:4]};
    xorOut  = opA ^ opB;
    xorZero = (xorOut == '0);
    opBZero = (opB == '0);
  end
endmodule // msxe_alu

// *** hw/msxe_exec.sv ***
// execution unit for nibble swap, skips, table reads and exclusive-or
`timescale 1ns/1ps
module msxe_exec
  import msxe_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // decoded instruction, one-cycle strobe
  input  wire logic              instValid,
  input  wire msxe_op_t          instOp,
  input  wire logic [2:0]        bitSel,
  input  wire logic [DATA_W-1:0] immData,
  input  wire logic [DATA_W-1:0] memRdata,
  input  wire logic [ROM_AW-1:0] progCounter,
  input  wire logic [DATA_W-1:0] table_pointer,
  // program ROM read port, data valid in the same cycle that romRd is high
  input  wire logic [ROM_W-1:0]  romData,
  output logic                   romRd,
  output logic [ROM_AW-1:0]      romAddr,
  // data memory write
  output logic                   memWe,
  output logic [DATA_W-1:0]      memWdata,
  // pipeline control
  output logic                   flushFetch,
  output logic                   busy,
  // architectural state
  output logic [DATA_W-1:0]      working_register,
  output logic [HIGH_W-1:0]      table_high_latch,
  output logic [FLAG_W-1:0]      flags
);
  typedef enum logic [1:0] {ST_RUN, ST_DUMMY, ST_TABLE} msxe_state_t;

  msxe_state_t       state_r, state_nxt;
  logic [DATA_W-1:0] wreg_r, wreg_nxt;
  logic [HIGH_W-1:0] tblHigh_r, tblHigh_nxt;
  logic              busy_r, busy_nxt;
  logic [FLAG_W-1:0] flags_r, flags_nxt;
  logic              romRd_r, romRd_nxt;
  logic [ROM_AW-1:0] romAddr_r, romAddr_nxt;
  logic              memWe_r, memWe_nxt;
  logic [DATA_W-1:0] memWdata_r, memWdata_nxt;
  logic              flush_r, flush_nxt;
  logic [DATA_W-1:0] swapOut, xorOut, xorOperand;
  logic              xorZero, opBZero;
  logic              takeSkip, accept;

  function automatic logic [FLAG_W-1:0] setZero(input logic [FLAG_W-1:0] f, input logic z);
    logic [FLAG_W-1:0] r;
    r = f;
    r[ZERO_BIT] = z;
    return r;
  endfunction

  always_comb begin
    xorOperand = (instOp == OP_XOR_WREG_IMM) ? immData : memRdata;
  end

  msxe_alu u_alu (
    .opA     (wreg_r),
    .opB     ((instOp == OP_NIBBLE_EXCHANGE_TO_WREG || instOp == OP_SKIP_IF_NULL_BYTE ||
               instOp == OP_COPY_THEN_SKIP_IF_NULL) ? memRdata : xorOperand),
    .swapOut (swapOut),
    .xorOut  (xorOut),
    .xorZero (xorZero),
    .opBZero (opBZero)
  );

  always_comb begin
    accept   = instValid && (state_r == ST_RUN);
    takeSkip = 1'b0;
    case (instOp)
      OP_SKIP_IF_NULL_BYTE:      takeSkip = opBZero;
      OP_COPY_THEN_SKIP_IF_NULL: takeSkip = opBZero;
      OP_SKIP_IF_BIT_CLEAR:      takeSkip = ~memRdata[bitSel];
      default:                   takeSkip = 1'b0;
    endcase
  end

  always_comb begin
    state_nxt    = state_r;
    wreg_nxt     = wreg_r;
    tblHigh_nxt  = tblHigh_r;
    flags_nxt    = flags_r;
    romRd_nxt    = 1'b0;
    romAddr_nxt  = romAddr_r;
    memWe_nxt    = 1'b0;
    memWdata_nxt = memWdata_r;
    flush_nxt    = 1'b0;
    case (state_r)
      ST_RUN: begin
        if (accept) begin
          if (takeSkip) begin
            flush_nxt = 1'b1;
            state_nxt = ST_DUMMY;
          end
          // no skip: stays in ST_RUN, one cycle, unless a table read moves to ST_TABLE
          case (instOp)
            OP_NIBBLE_EXCHANGE_TO_WREG: wreg_nxt = swapOut;
            OP_COPY_THEN_SKIP_IF_NULL:  wreg_nxt = memRdata;
            OP_TABLE_READ_CURRENT_PAGE: begin
              romRd_nxt   = 1'b1;
              romAddr_nxt = {progCounter[ROM_AW-1:DATA_W], table_pointer};
              state_nxt   = ST_TABLE;
            end
            OP_TABLE_READ_LAST_PAGE: begin
              romRd_nxt   = 1'b1;
              romAddr_nxt = {LAST_PAGE, table_pointer};
              state_nxt   = ST_TABLE;
            end
            OP_XOR_WREG_MEM, OP_XOR_WREG_IMM: begin
              wreg_nxt  = xorOut;
              flags_nxt = setZero(flags_r, xorZero);
            end
            OP_EXCLUSIVE_OR_INTO_MEMORY: begin
              memWe_nxt    = 1'b1;
              memWdata_nxt = xorOut;
              flags_nxt    = setZero(flags_r, xorZero);
            end
            default: ;
          endcase
        end
      end
      ST_DUMMY: state_nxt = ST_RUN;
      ST_TABLE: begin
        // rom answers in the same cycle that the read strobe is high
        memWe_nxt    = 1'b1;
        memWdata_nxt = romData[DATA_W-1:0];
        tblHigh_nxt  = romData[ROM_W-1:DATA_W];
        state_nxt    = ST_RUN;
      end
      default: state_nxt = ST_RUN;
    endcase
    // busy gets its own flop so the fetch stage sees a glitch-free level
    busy_nxt     = (state_nxt != ST_RUN);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r    <= ST_RUN;
      wreg_r     <= WREG_RST;
      tblHigh_r  <= TABLE_HIGH_RST;
      flags_r    <= FLAGS_RST;
      romRd_r    <= 1'b0;
      romAddr_r  <= '0;
      memWe_r    <= 1'b0;
      memWdata_r <= '0;
      flush_r    <= 1'b0;
      busy_r     <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      wreg_r     <= wreg_nxt;
      tblHigh_r  <= tblHigh_nxt;
      flags_r    <= flags_nxt;
      romRd_r    <= romRd_nxt;
      romAddr_r  <= romAddr_nxt;
      memWe_r    <= memWe_nxt;
      memWdata_r <= memWdata_nxt;
      flush_r    <= flush_nxt;
      busy_r     <= busy_nxt;
    end
  end

  // busy covers the dummy and table cycles; requests then are dropped
  assign busy             = busy_r;
  assign romRd            = romRd_r;
  assign romAddr          = romAddr_r;
  assign memWe            = memWe_r;
  assign memWdata         = memWdata_r;
  assign flushFetch       = flush_r;
  assign working_register = wreg_r;
  assign table_high_latch = tblHigh_r;
  assign flags            = flags_r;

  property p_skip_flush;
    @(posedge clk) disable iff (!nrst) accept && takeSkip |=> flushFetch && busy ##1 !busy;
  endproperty
  a_skip_flush: assert property (p_skip_flush) else $error("skip not two cycles");

  property p_noskip;
    @(posedge clk) disable iff (!nrst)
      accept && !takeSkip && instOp inside {OP_SKIP_IF_NULL_BYTE, OP_SKIP_IF_BIT_CLEAR}
      |=> !flushFetch && !busy;
  endproperty
  a_noskip: assert property (p_noskip) else $error("unmet skip stalled");

  property p_swap;
    @(posedge clk) disable iff (!nrst) accept && instOp == OP_NIBBLE_EXCHANGE_TO_WREG
      |=> working_register == {$past(memRdata[3:0]), $past(memRdata[7:4])}
          && flags == $past(flags) && !memWe;
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");

  property p_nullskip;
    @(posedge clk) disable iff (!nrst) accept && instOp == OP_SKIP_IF_NULL_BYTE
      |=> flushFetch == ($past(memRdata) == 8'h00) && flags == $past(flags);
  endproperty
  a_nullskip: assert property (p_nullskip) else $error("null skip wrong");

  property p_copyskip;
    @(posedge clk) disable iff (!nrst) accept && instOp == OP_COPY_THEN_SKIP_IF_NULL
      |=> working_register == $past(memRdata) && flushFetch == ($past(memRdata) == 8'h00);
  endproperty
  a_copyskip: assert property (p_copyskip) else $error("copy skip wrong");

  property p_bitskip;
    @(posedge clk) disable iff (!nrst) accept && instOp == OP_SKIP_IF_BIT_CLEAR
      |=> flushFetch == !$past(memRdata[bitSel]) && !memWe;
  endproperty
  a_bitskip: assert property (p_bitskip) else $error("bit skip wrong");

  property p_tabc;
    @(posedge clk) disable iff (!nrst) accept && instOp == OP_TABLE_READ_CURRENT_PAGE
      |=> romRd && romAddr == {$past(progCounter[11:8]), $past(table_pointer)}
          ##1 memWe && memWdata == $past(romData[7:0]);
  endproperty
  a_tabc: assert property (p_tabc) else $error("current page read wrong");

  property p_tabl;
    @(posedge clk) disable iff (!nrst) accept && instOp == OP_TABLE_READ_LAST_PAGE
      |=> romRd && romAddr == {4'hf, $past(table_pointer)} ##1 table_high_latch == $past(romData[14:8]);
  endproperty
  a_tabl: assert property (p_tabl) else $error("last page read wrong");

  property p_xor;
    @(posedge clk) disable iff (!nrst) accept && instOp inside {OP_XOR_WREG_MEM, OP_XOR_WREG_IMM}
      |=> working_register ==
            ($past(working_register) ^ $past(instOp == OP_XOR_WREG_IMM ? immData : memRdata))
          && flags[ZERO_BIT] == (working_register == 8'h00)
          && (flags & 8'hfb) == ($past(flags) & 8'hfb);
  endproperty
  a_xor: assert property (p_xor) else $error("xor to wreg wrong");

  property p_exclusive_or_into_memory;
    @(posedge clk) disable iff (!nrst) accept && instOp == OP_EXCLUSIVE_OR_INTO_MEMORY
      |=> memWe && memWdata == ($past(wreg_r) ^ $past(memRdata))
          && flags[ZERO_BIT] == (memWdata == 8'h00)
          && working_register == $past(working_register);
  endproperty
  a_exclusive_or_into_memory: assert property (p_exclusive_or_into_memory) else $error("xor into memory wrong");

  property p_xorflags;
    @(posedge clk) disable iff (!nrst) accept && instOp == OP_XOR_WREG_IMM
      |=> (flags & 8'hfb) == ($past(flags) & 8'hfb)
          && working_register == ($past(working_register) ^ $past(immData));
  endproperty
  a_xorflags: assert property (p_xorflags) else $error("xor immediate wrong");

  c_skip:  cover property (@(posedge clk) accept && takeSkip);
  c_tab:   cover property (@(posedge clk) accept && instOp == OP_TABLE_READ_LAST_PAGE);
  c_xorz:  cover property (@(posedge clk) accept && instOp == OP_XOR_WREG_MEM && xorZero);
endmodule // msxe_exec

// *** tb/msxe_rom_model.sv ***
// program rom model answering the table reads of the execution block
`timescale 1ns/1ps
module msxe_rom_model
  import msxe_pkg::*;
(
  // rom read port
  input  wire logic              clk,
  input  wire logic              romRd,
  input  wire logic [ROM_AW-1:0] romAddr,
  output logic      [ROM_W-1:0]  romData
);
  logic [ROM_W-1:0] lastWord_r = '0;
  // outside the read cycle the bus shows the inverse, so a late sample is caught
  always_comb romData = romRd ? {romAddr[6:0] ^ 7'h2a, romAddr[7:0] ^ romAddr[11:4]}
                              : ~lastWord_r;
  always @(posedge clk) if (romRd) lastWord_r <= romData;
endmodule // msxe_rom_model

// *** tb/mcu_swap_skip_table_xor_exec_tb.sv ***
// self-checking bench for the swap, skip, table and xor execution block
`timescale 1ns/1ps
module mcu_swap_skip_table_xor_exec_tb;
  import msxe_pkg::*;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic              instValid = 1'b0;
  msxe_op_t          instOp = OP_NONE;
  logic [2:0]        bitSel = 3'h0;
  logic [DATA_W-1:0] immData = 8'h00;
  logic [DATA_W-1:0] memRdata = 8'h00;
  logic [ROM_AW-1:0] progCounter = 12'h3a5;
  logic [DATA_W-1:0] tablePtr = 8'h5c;
  logic [ROM_W-1:0]  romData;
  logic              romRd, memWe, flushFetch, busy;
  logic [ROM_AW-1:0] romAddr;
  logic [DATA_W-1:0] memWdata, wreg, expW;
  logic [HIGH_W-1:0] tblHigh;
  logic [FLAG_W-1:0] flags, expF;
  int                failures = 0;
  int                checked = 0;
  int                cyc = 0;

  msxe_exec u_dut (.clk(clk), .nrst(nrst), .instValid(instValid), .instOp(instOp),
    .bitSel(bitSel), .immData(immData), .memRdata(memRdata), .progCounter(progCounter),
    .table_pointer(tablePtr), .romData(romData), .romRd(romRd), .romAddr(romAddr),
    .memWe(memWe), .memWdata(memWdata), .flushFetch(flushFetch), .busy(busy),
    .working_register(wreg), .table_high_latch(tblHigh), .flags(flags));
  msxe_rom_model u_rom (.clk(clk), .romRd(romRd), .romAddr(romAddr), .romData(romData));

  always #2.5 clk = ~clk;
  // ceiling well above the hundred or so cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // drive one instruction for one cycle, return in the cycle after it was taken
  task automatic go(input msxe_op_t op, input logic [7:0] mem, input logic [7:0] imm,
                    input logic [2:0] bs);
    @(negedge clk);
    instValid = 1'b1;
    instOp = op;
    memRdata = mem;
    immData = imm;
    bitSel = bs;
    @(negedge clk);
    instValid = 1'b0;
    memRdata = ~mem;
  endtask

  task automatic skipchk(input msxe_op_t op, input logic [7:0] mem, input logic [2:0] bs,
                         input logic sk);
    go(op, mem, 8'h00, bs);
    chk("flushFetch", flushFetch, sk);
    chk("busy", busy, sk);
    chk("memWe", memWe, 0);
    chk("flags", flags, expF);
    @(negedge clk);
    chk("busy end", busy, 0);
  endtask

  task automatic xchk(input msxe_op_t op, input logic [7:0] mem, input logic [7:0] imm,
                      input bit toMem);
    logic [7:0] r;
    r = expW ^ ((op == OP_XOR_WREG_IMM) ? imm : mem);
    go(op, mem, imm, 3'h0);
    expF = (r == 8'h00) ? 8'h04 : 8'h00;
    if (toMem) begin
      chk("memWe", memWe, 1);
      chk("memWdata", memWdata, r);
    end else begin
      expW = r;
      chk("memWe", memWe, 0);
    end
    chk("wreg", wreg, expW);
    chk("flags", flags, expF);
  endtask

  task automatic t_xor;
    xchk(OP_XOR_WREG_MEM, 8'h5a, 8'h00, 0);
    xchk(OP_XOR_WREG_IMM, 8'h00, 8'h5a, 0);
    xchk(OP_EXCLUSIVE_OR_INTO_MEMORY, 8'h3c, 8'h00, 1);
    xchk(OP_XOR_WREG_MEM, 8'hc3, 8'h00, 0);
    xchk(OP_EXCLUSIVE_OR_INTO_MEMORY, 8'hc3, 8'h00, 1);
    $display("done xor");
  endtask

  task automatic t_swap;
    go(OP_NIBBLE_EXCHANGE_TO_WREG, 8'h5a, 8'h00, 3'h0);
    expW = 8'ha5;
    chk("wreg", wreg, expW);
    chk("memWe", memWe, 16'h0);
    chk("flags", flags, expF);
    $display("done swap");
  endtask

  task automatic t_skip;
    skipchk(OP_SKIP_IF_NULL_BYTE, 8'h00, 3'h0, 1);
    skipchk(OP_SKIP_IF_NULL_BYTE, 8'h80, 3'h0, 0);
    chk("wreg", wreg, expW);
    skipchk(OP_COPY_THEN_SKIP_IF_NULL, 8'h96, 3'h0, 0);
    chk("wreg", wreg, 8'h96);
    skipchk(OP_COPY_THEN_SKIP_IF_NULL, 8'h00, 3'h0, 1);
    chk("wreg", wreg, 8'h00);
    expW = 8'h00;
    for (int i = 0; i < 8; i++) begin
      skipchk(OP_SKIP_IF_BIT_CLEAR, ~(8'h01 << i), 3'(i), 1);
      skipchk(OP_SKIP_IF_BIT_CLEAR, 8'h01 << i, 3'(i), 0);
    end
    $display("done skip");
  endtask

  // a request raised while busy must be ignored
  task automatic t_table(input msxe_op_t op, input logic [3:0] page);
    logic [ROM_AW-1:0] a;
    a = {page, tablePtr};
    @(negedge clk);
    instValid = 1'b1;
    instOp = op;
    memRdata = 8'h00;
    @(negedge clk);
    // valid stays high: the next request lands in the busy cycle
    instOp = OP_XOR_WREG_IMM;
    immData = 8'hff;
    chk("romRd", romRd, 16'h1);
    chk("romAddr", romAddr, a);
    chk("busy", busy, 16'h1);
    @(negedge clk);
    instValid = 1'b0;
    chk("memWe", memWe, 16'h1);
    chk("memWdata", memWdata, a[7:0] ^ a[11:4]);
    chk("tblHigh", tblHigh, a[6:0] ^ 7'h2a);
    chk("wreg", wreg, expW);
    chk("flags", flags, expF);
    chk("busy end", busy, 16'h0);
    $display("done table");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    expW = WREG_RST;
    expF = FLAGS_RST;
    chk("wreg rst", wreg, expW);
    chk("tblHigh rst", tblHigh, TABLE_HIGH_RST);
    chk("flags rst", flags, expF);
    t_xor();
    t_swap();
    t_skip();
    t_table(OP_TABLE_READ_CURRENT_PAGE, progCounter[11:8]);
    tablePtr = 8'hff;
    t_table(OP_TABLE_READ_LAST_PAGE, LAST_PAGE);
    tally_and_finish();
  end
endmodule // mcu_swap_skip_table_xor_exec_tb
